// File: common/etx_regs.svh
// Register offsets, field positions, reset values and frame limits
// for the transmit statistics block. Definitions only.
`ifndef ETX_REGS_SVH
`define ETX_REGS_SVH

// ****************************************
// Counter, control and status offsets (byte addresses)
// ****************************************
`define ETX_OFF_GOOD      8'h00
`define ETX_OFF_BCAST     8'h04
`define ETX_OFF_GROUP     8'h08
`define ETX_OFF_PAUSE     8'h0C
`define ETX_OFF_DEFER     8'h10
`define ETX_OFF_COLL      8'h14
`define ETX_OFF_ONE       8'h18
`define ETX_OFF_SEVERAL   8'h1C
`define ETX_OFF_EXCESS    8'h20
`define ETX_OFF_LATE      8'h24
`define ETX_OFF_UNDERRUN  8'h28
`define ETX_OFF_CARRIER   8'h2C
`define ETX_OFF_BYTES     8'h30
`define ETX_OFF_SIZE64    8'h34
`define ETX_OFF_SIZE65    8'h38
`define ETX_OFF_LAST_CNT  8'h38
`define ETX_OFF_CTRL      8'h40
`define ETX_OFF_STATUS    8'h44

// ****************************************
// Control and status fields
// ****************************************
`define ETX_CTRL_EN_BIT   0
`define ETX_CTRL_CLR_BIT  1
`define ETX_CTRL_RESET    2'h1
`define ETX_STAT_ACT_BIT  0
`define ETX_STAT_CNT_LSB  8

// ****************************************
// Frame limits
// ****************************************
`define ETX_LATE_BYTES    16'h0040
`define ETX_MAX_COLL      5'h10
`define ETX_SIZE_64       16'h0040
`define ETX_SIZE_65       16'h0041
`define ETX_SIZE_127      16'h007F

`endif

// File: common/etx_pkg.sv
// Types shared by the transmit statistics block.
// Assumes etx_regs.svh supplies the numeric constants.
`default_nettype none

package etx_pkg;

  typedef enum logic [1:0] {
    ETX_IDLE,
    ETX_FRAME,
    ETX_DONE
  } etx_state_t;

  typedef logic [15:0] etx_len_t;

  typedef enum logic [3:0] {
    ETX_C_GOOD, ETX_C_BCAST, ETX_C_GROUP, ETX_C_PAUSE, ETX_C_DEFER,
    ETX_C_COLL, ETX_C_ONE, ETX_C_SEVERAL, ETX_C_EXCESS, ETX_C_LATE,
    ETX_C_UNDERRUN, ETX_C_CARRIER, ETX_C_BYTES, ETX_C_SIZE64, ETX_C_SIZE65
  } etx_cnt_idx_t;

endpackage

`default_nettype wire

// File: hdl/etx_stats.sv
// Transmit statistics counters of an Ethernet MAC, with two size
// buckets shared with receive. Inputs are synchronous to mclk and come
// from the MAC transmit engine; a register port reads the counters.
`timescale 1ns/100ps
`include "etx_regs.svh"
`default_nettype none

module etx_stats
  import etx_pkg::*;
#(
  parameter int CNT_W = 32
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Transmit engine events
  input wire logic tx_frame_start,
  input wire logic tx_dest_bcast,
  input wire logic tx_dest_group,
  input wire logic tx_hw_pause,
  input wire logic tx_medium_busy,
  input wire logic tx_retry_start,
  input wire logic tx_byte,
  input wire logic tx_collision,
  input wire logic tx_underrun,
  input wire logic tx_carrier_lost,
  input wire logic tx_frame_end,
  // Link mode and receive side
  input wire logic full_duplex,
  input wire logic flow_ctrl_active,
  input wire logic rx_frame_start,
  input wire logic rx_frame_end,
  input wire logic [15:0] rx_frame_len,
  // Actions back to the transmit engine
  output logic jam_req,
  output logic tx_abandon
);

  localparam int NCNT = 15;

  // ****************************************
  // Helpers
  // ****************************************
  // {65..127, exactly 64}
  function automatic logic [1:0] size_bucket(input etx_len_t len);
    size_bucket[0] = (len == `ETX_SIZE_64);
    size_bucket[1] = (len >= `ETX_SIZE_65) && (len <= `ETX_SIZE_127);
  endfunction

  function automatic logic [CNT_W-1:0] add2(input logic a, input logic b);
    add2 = CNT_W'(a) + CNT_W'(b);
  endfunction

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta_r, rst_sync_b;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_b <= rst_meta_r;
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  logic [1:0] ctrl_r;
  logic count_en;
  logic clr_all;

  assign count_en = ctrl_r[`ETX_CTRL_EN_BIT];
  assign clr_all = reg_wr && (reg_addr == `ETX_OFF_CTRL) && reg_wdata[`ETX_CTRL_CLR_BIT];

  // Clear bit is a one-shot, never stored
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ctrl_r <= `ETX_CTRL_RESET;
    end else if (reg_wr && reg_addr == `ETX_OFF_CTRL) begin
      ctrl_r <= {1'b0, reg_wdata[`ETX_CTRL_EN_BIT]};
    end
  end

  // ****************************************
  // Per-frame tracking
  // ****************************************
  etx_state_t state_r;
  logic bcast_r, group_r, pause_r, defer_r;
  logic under_r, carrier_r;
  logic [4:0] coll_r;
  etx_len_t att_len_r;
  logic frame_act;
  logic late_now, coll_nonlate, coll_excess, end_now;
  logic [4:0] coll_sum;

  assign frame_act = (state_r == ETX_FRAME);
  // Past 512 bit-times means more than 64 bytes into this attempt
  assign late_now = att_len_r > `ETX_LATE_BYTES;
  assign coll_nonlate = frame_act && tx_collision && !late_now;
  assign coll_sum = coll_r + 5'(coll_nonlate);
  assign coll_excess = coll_nonlate && (coll_sum == `ETX_MAX_COLL);
  // Late collision and the sixteenth collision both end the frame
  assign end_now = frame_act && (tx_frame_end || (tx_collision && late_now) || coll_excess);

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_r <= ETX_IDLE;
    end else begin
      case (state_r)
        ETX_IDLE: begin
          if (tx_frame_start) begin
            state_r <= ETX_FRAME;
          end
        end
        ETX_FRAME: begin
          if (end_now) begin
            state_r <= ETX_DONE;
          end
        end
        default: begin
          state_r <= ETX_IDLE;
        end
      endcase
    end
  end

  // Destination class and first-attempt deferral, caught at frame start
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      bcast_r <= 1'b0;
      group_r <= 1'b0;
      pause_r <= 1'b0;
      defer_r <= 1'b0;
    end else if (state_r == ETX_IDLE && tx_frame_start) begin
      bcast_r <= tx_dest_bcast;
      group_r <= tx_dest_group && !tx_dest_bcast;
      // Pause generation is a full-duplex feature only
      pause_r <= tx_hw_pause && full_duplex;
      defer_r <= tx_medium_busy;
    end
  end

  // Error history; carrier loss requests an abandon, but the frame still ends only at tx_frame_end, a late collision or the sixteenth collision
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      under_r <= 1'b0;
      carrier_r <= 1'b0;
      coll_r <= 5'h0;
    end else if (state_r == ETX_IDLE && tx_frame_start) begin
      under_r <= 1'b0;
      carrier_r <= 1'b0;
      coll_r <= 5'h0;
    end else if (frame_act) begin
      under_r <= under_r || tx_underrun;
      carrier_r <= carrier_r || tx_carrier_lost;
      coll_r <= coll_sum;
    end
  end

  // Length of the current attempt; a retry restarts it
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      att_len_r <= '0;
    end else if ((state_r == ETX_IDLE && tx_frame_start) || (frame_act && tx_retry_start)) begin
      att_len_r <= '0;
    end else if (frame_act && tx_byte) begin
      att_len_r <= att_len_r + 16'h0001;
    end
  end

  // ****************************************
  // Frame outcome, one pulse per frame
  // ****************************************
  logic fin_r;
  logic fin_good_r, fin_late_r, fin_excess_r, fin_under_r, fin_carrier_r;
  logic fin_bcast_r, fin_group_r, fin_pause_r, fin_defer_r;
  logic [4:0] fin_coll_r;
  etx_len_t fin_len_r;
  logic end_late, end_under, end_carrier;

  assign end_late = tx_collision && late_now;
  assign end_under = under_r || tx_underrun;
  assign end_carrier = carrier_r || tx_carrier_lost;

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      fin_r <= 1'b0;
      fin_good_r <= 1'b0;
      fin_late_r <= 1'b0;
      fin_excess_r <= 1'b0;
      fin_under_r <= 1'b0;
      fin_carrier_r <= 1'b0;
      fin_bcast_r <= 1'b0;
      fin_group_r <= 1'b0;
      fin_pause_r <= 1'b0;
      fin_defer_r <= 1'b0;
      fin_coll_r <= 5'h0;
      fin_len_r <= '0;
    end else begin
      fin_r <= end_now;
      if (end_now) begin
        fin_late_r <= end_late;
        fin_excess_r <= coll_excess && !end_late;
        fin_under_r <= end_under;
        fin_carrier_r <= end_carrier;
        fin_good_r <= !end_late && !coll_excess && !end_under && !end_carrier;
        fin_bcast_r <= bcast_r;
        fin_group_r <= group_r;
        fin_pause_r <= pause_r;
        fin_defer_r <= defer_r;
        fin_coll_r <= coll_sum;
        fin_len_r <= att_len_r + 16'(tx_byte);
      end
    end
  end

  // ****************************************
  // Jam and abandon requests
  // ****************************************
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      jam_req <= 1'b0;
      tx_abandon <= 1'b0;
    end else begin
      jam_req <= coll_nonlate;
      tx_abandon <= frame_act && ((tx_collision && late_now) || coll_excess || tx_carrier_lost);
    end
  end

  // ****************************************
  // Increment decisions
  // ****************************************
  logic [CNT_W-1:0] inc [NCNT];
  logic [1:0] tx_bkt, rx_bkt;
  logic tx_clean, tx_clean64, coll_rx;

  assign tx_bkt = size_bucket(fin_len_r);
  assign rx_bkt = size_bucket(rx_frame_len);
  // Carrier-cut frames still land in the 64-byte bucket
  assign tx_clean64 = fin_r && !fin_late_r && !fin_excess_r && !fin_under_r;
  assign tx_clean = tx_clean64 && !fin_carrier_r;
  assign coll_rx = rx_frame_start && !full_duplex && flow_ctrl_active;

  // CRC status is not an input, so it cannot sway any count
  always_comb begin
    inc[ETX_C_GOOD] = add2(fin_r && fin_good_r, 1'b0);
    inc[ETX_C_BCAST] = add2(fin_r && fin_good_r && fin_bcast_r, 1'b0);
    inc[ETX_C_GROUP] = add2(fin_r && fin_good_r && fin_group_r, 1'b0);
    inc[ETX_C_PAUSE] = add2(fin_r && fin_good_r && fin_pause_r, 1'b0);
    inc[ETX_C_DEFER] = add2(fin_r && fin_good_r && fin_defer_r && fin_coll_r == 5'h0, 1'b0);
    inc[ETX_C_COLL] = add2(frame_act && tx_collision, coll_rx);
    inc[ETX_C_ONE] = add2(fin_r && fin_good_r && fin_coll_r == 5'h01, 1'b0);
    inc[ETX_C_SEVERAL] = add2(fin_r && fin_good_r && fin_coll_r >= 5'h02 && fin_coll_r <= 5'h0F,
                              1'b0);
    inc[ETX_C_EXCESS] = add2(fin_r && fin_excess_r && !fin_late_r, 1'b0);
    inc[ETX_C_LATE] = add2(fin_r && fin_late_r, 1'b0);
    inc[ETX_C_UNDERRUN] = add2(fin_r && fin_under_r, 1'b0);
    inc[ETX_C_CARRIER] = add2(fin_r && fin_carrier_r, 1'b0);
    inc[ETX_C_BYTES] = (fin_r && fin_good_r) ? CNT_W'(fin_len_r) : '0;
    inc[ETX_C_SIZE64] = add2(tx_clean64 && tx_bkt[0], rx_frame_end && rx_bkt[0]);
    inc[ETX_C_SIZE65] = add2(tx_clean && tx_bkt[1], rx_frame_end && rx_bkt[1]);
  end

  // ****************************************
  // Counter array
  // ****************************************
  logic [CNT_W-1:0] cnt_r [NCNT];

  // A write clears one counter; an event in the same cycle still counts
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      for (int i = 0; i < NCNT; i++) begin
        cnt_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NCNT; i++) begin
        if (clr_all || (reg_wr && reg_addr == 8'(4 * i))) begin
          cnt_r[i] <= count_en ? inc[i] : '0;
        end else if (count_en) begin
          cnt_r[i] <= cnt_r[i] + inc[i];
        end
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  logic [31:0] status_w;

  assign status_w = {16'h0000, 3'h0, coll_r, 7'h00, frame_act};

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      reg_rdata <= 32'h0000_0000;
    end else if (!reg_rd) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_addr <= `ETX_OFF_LAST_CNT && reg_addr[1:0] == 2'h0) begin
      reg_rdata <= 32'(cnt_r[reg_addr[5:2]]);
    end else if (reg_addr == `ETX_OFF_CTRL) begin
      reg_rdata <= {30'h0000_0000, ctrl_r};
    end else if (reg_addr == `ETX_OFF_STATUS) begin
      reg_rdata <= status_w;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_sync_b);

  sequence s_late_hit;
    frame_act && tx_collision && late_now;
  endsequence

  sequence s_tenth_six;
    coll_nonlate && coll_r == 5'h0F;
  endsequence

  sequence s_outcome(late, excess);
    fin_r && fin_late_r == late && fin_excess_r == excess;
  endsequence

  chk_good_step: assert property (
    (fin_r && fin_good_r && count_en && !reg_wr) |=> cnt_r[ETX_C_GOOD] == $past(cnt_r[ETX_C_GOOD]) + 1'b1)
    else $error("good count did not step");

  chk_bcast_group_excl: assert property (
    !(inc[ETX_C_BCAST] != '0 && inc[ETX_C_GROUP] != '0))
    else $error("broadcast counted as group");

  chk_pause_full_duplex: assert property (
    (state_r == ETX_IDLE && tx_frame_start && !full_duplex) |=> !pause_r)
    else $error("pause tracked in half duplex");

  chk_late_abandon: assert property (
    s_late_hit |=> s_outcome(1'b1, 1'b0) ##0 tx_abandon)
    else $error("late collision did not abandon");

  chk_excess_abandon: assert property (
    s_tenth_six |=> s_outcome(1'b0, 1'b1) ##0 tx_abandon ##1 !fin_r)
    else $error("sixteenth collision not excessive");

  chk_jam_follow: assert property (
    coll_nonlate |=> jam_req ##1 (jam_req == $past(coll_nonlate)))
    else $error("jam missing after collision");

  chk_late_dominates: assert property (
    (fin_r && fin_late_r) |-> inc[ETX_C_ONE] == '0 && inc[ETX_C_SEVERAL] == '0 && inc[ETX_C_EXCESS] == '0)
    else $error("late frame in collision buckets");

  chk_once_frame: assert property (
    fin_r |=> !fin_r [*2])
    else $error("outcome pulsed twice");

  chk_rx_collision: assert property (
    (coll_rx && !(frame_act && tx_collision)) |-> inc[ETX_C_COLL] == CNT_W'(1))
    else $error("flow control receive not counted");

endmodule  // etx_stats

`default_nettype wire

// File: tb/etx_eng_model.sv
// Transmit engine model that drives the event inputs of the statistics block.
// Assumes a free-running mclk and calls to send from the bench.
`timescale 1ns/100ps
`default_nettype none

module etx_eng_model (
  // Clock
  input wire logic mclk,
  // Frame events
  output logic tx_frame_start,
  output logic tx_dest_bcast,
  output logic tx_dest_group,
  output logic tx_hw_pause,
  output logic tx_medium_busy,
  output logic tx_retry_start,
  output logic tx_byte,
  output logic tx_collision,
  output logic tx_underrun,
  output logic tx_carrier_lost,
  output logic tx_frame_end
);
  logic [3:0] fl = 4'h0;

  initial begin
    {tx_frame_start, tx_retry_start, tx_byte, tx_collision} = 4'h0;
    {tx_underrun, tx_carrier_lost, tx_frame_end} = 3'h0;
    {tx_dest_bcast, tx_dest_group, tx_hw_pause, tx_medium_busy} = 4'h0;
  end

  // One clock of events; flags are garbled away from the start pulse
  task automatic cyc(input logic [6:0] p);
    @(posedge mclk);
    {tx_frame_start, tx_retry_start, tx_byte, tx_collision} <= p[6:3];
    {tx_underrun, tx_carrier_lost, tx_frame_end} <= p[2:0];
    {tx_dest_bcast, tx_dest_group, tx_hw_pause, tx_medium_busy} <= p[6] ? fl : ~fl;
  endtask

  // Flags are {broadcast, group, hardware pause, medium busy}
  task automatic send(input logic [3:0] f, input int nc, input bit late, input int len,
                      input bit und, input bit crl);
    fl = f;
    cyc(7'b1000000);
    for (int i = 0; i < nc; i++) begin
      cyc(7'b0010000);
      cyc(7'b0001000);
      cyc(7'b0000000);
      if (i < 15) cyc(7'b0100000);
    end
    if (late) begin
      repeat (65) cyc(7'b0010000);
      cyc(7'b0001000);
    end else if (nc < 16) begin
      for (int i = 1; i < len; i++) cyc({3'b001, 1'b0, i == 2 && und, i == 1 && crl, 1'b0});
      cyc(7'b0010001);
    end
    repeat (2) cyc(7'b0000000);
  endtask
endmodule // etx_eng_model

`default_nettype wire

// File: tb/etx_stats_test.sv
// Self-checking bench for the transmit statistics counters.
// Assumes the engine model drives the frame events and the bench the rest.
`timescale 1ns/100ps
`include "etx_regs.svh"
`default_nettype none

`define CHK(got, want) begin checked++; if ((got) !== (want)) begin num_errors++; \
  $display("Error at %0t: got %h expected %h", $time, got, want); end end

module etx_stats_test
  import etx_pkg::*;
;
  logic mclk, rst_b, reg_wr, reg_rd, full_duplex, flow_ctrl_active;
  logic rx_frame_start, rx_frame_end, jam_req, tx_abandon, en;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [15:0] rx_frame_len;
  logic tx_frame_start, tx_dest_bcast, tx_dest_group, tx_hw_pause, tx_medium_busy;
  logic tx_retry_start, tx_byte, tx_collision, tx_underrun, tx_carrier_lost, tx_frame_end;
  logic [31:0] exp [15];
  int num_errors, checked, cycles, jams, jams_x, aborts, aborts_x;

  etx_stats #(.CNT_W(32)) dut (.*);
  etx_eng_model eng (.*);

  initial mclk = 1'b0;
  always #25 mclk = ~mclk;

  // Hang guard, and counts of the action pulses back to the engine
  always @(posedge mclk) begin
    cycles++;
    jams += int'(jam_req === 1'b1);
    aborts += int'(tx_abandon === 1'b1);
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end

  // ****************************************
  // Bus and frame tasks
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic check_all();
    repeat (3) @(posedge mclk);
    for (int i = 0; i < 15; i++) begin
      rd(8'(i * 4));
      `CHK(d, exp[i])
    end
    `CHK(jams, jams_x)
    `CHK(aborts, aborts_x)
  endtask

  task automatic frm(input logic [3:0] f, input int nc, input bit late, input int len,
                     input bit und = 1'b0, input bit crl = 1'b0);
    bit ab, ok, cl;
    ab = late || nc == 16;
    ok = !ab && !und && !crl;
    cl = !ab && !und;
    eng.send(f, nc, late, len, und, crl);
    jams_x += nc;
    aborts_x += int'(ab || crl);
    if (en) begin
      exp[ETX_C_COLL] += nc + late;
      exp[ETX_C_LATE] += late;
      exp[ETX_C_EXCESS] += (nc == 16);
      exp[ETX_C_ONE] += ok && nc == 1;
      exp[ETX_C_SEVERAL] += ok && nc > 1;
      exp[ETX_C_GOOD] += ok;
      exp[ETX_C_BYTES] += ok ? len : 0;
      exp[ETX_C_BCAST] += ok && f[3];
      exp[ETX_C_GROUP] += ok && f[2] && !f[3];
      exp[ETX_C_PAUSE] += ok && f[1] && full_duplex;
      exp[ETX_C_DEFER] += ok && f[0] && nc == 0;
      exp[ETX_C_UNDERRUN] += und;
      exp[ETX_C_CARRIER] += crl;
      exp[ETX_C_SIZE64] += cl && len == 64;
      exp[ETX_C_SIZE65] += cl && !crl && len > 64 && len < 128;
    end
  endtask

  task automatic rxf(input logic [15:0] n);
    @(posedge mclk);
    rx_frame_start <= 1'b1;
    @(posedge mclk);
    rx_frame_start <= 1'b0;
    rx_frame_end <= 1'b1;
    rx_frame_len <= n;
    @(posedge mclk);
    rx_frame_end <= 1'b0;
    rx_frame_len <= ~n;
    exp[ETX_C_COLL] += !full_duplex && flow_ctrl_active;
    exp[ETX_C_SIZE64] += n == 16'h0040;
    exp[ETX_C_SIZE65] += n > 16'h0040 && n < 16'h0080;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    check_all();
    rd(`ETX_OFF_CTRL);
    `CHK(d, 32'h0000_0001)
    rd(8'h3C);
    `CHK(d, 32'h0000_0000)
    rd(8'h41);
    `CHK(d, 32'h0000_0000)
    rd(`ETX_OFF_STATUS);
    `CHK(d, 32'h0000_0000)
  endtask

  task automatic t_good();
    frm(4'b0000, 0, 0, 64);
    frm(4'b1100, 0, 0, 100);
    frm(4'b0100, 0, 0, 127);
    frm(4'b0100, 0, 0, 65);
    frm(4'b0000, 0, 0, 63);
    frm(4'b0000, 0, 0, 128);
    check_all();
  endtask

  task automatic t_pause();
    full_duplex <= 1'b1;
    frm(4'b0110, 0, 0, 64);
    frm(4'b0100, 0, 0, 64);
    full_duplex <= 1'b0;
    frm(4'b0110, 0, 0, 64);
    frm(4'b0001, 0, 0, 80);
    frm(4'b0001, 1, 0, 80);
    check_all();
  endtask

  task automatic t_coll();
    for (int n = 1; n <= 16; n++) frm(4'b0000, n, 0, 70);
    frm(4'b0000, 15, 1, 70);
    frm(4'b0000, 0, 1, 70);
    check_all();
  endtask

  task automatic t_err();
    frm(4'b0000, 0, 0, 64, 1, 0);
    frm(4'b0000, 0, 0, 64, 0, 1);
    frm(4'b0000, 2, 0, 100, 0, 1);
    frm(4'b0000, 0, 0, 100, 1, 1);
    check_all();
  endtask

  task automatic t_rx();
    flow_ctrl_active <= 1'b1;
    rxf(16'h0040);
    full_duplex <= 1'b1;
    rxf(16'h0064);
    full_duplex <= 1'b0;
    flow_ctrl_active <= 1'b0;
    rxf(16'h0080);
    rxf(16'h007F);
    check_all();
  endtask

  task automatic t_clear();
    wr(`ETX_OFF_GOOD, 32'h0000_0000);
    exp[ETX_C_GOOD] = 32'h0000_0000;
    check_all();
    wr(`ETX_OFF_CTRL, 32'h0000_0000);
    en = 1'b0;
    frm(4'b0100, 0, 0, 64);
    check_all();
    wr(`ETX_OFF_CTRL, 32'h0000_0003);
    en = 1'b1;
    exp = '{default: 32'h0000_0000};
    // Clear-all bit is one-shot, so only the enable reads back
    rd(`ETX_OFF_CTRL);
    `CHK(d, 32'h0000_0001)
    frm(4'b0000, 0, 0, 64);
    check_all();
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    rst_b = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    {reg_wr, reg_rd, full_duplex, flow_ctrl_active} = 4'h0;
    {rx_frame_start, rx_frame_end} = 2'h0;
    rx_frame_len = 16'h0000;
    en = 1'b1;
    exp = '{default: 32'h0000_0000};
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset();
    t_good();
    t_pause();
    t_coll();
    t_err();
    t_rx();
    t_clear();
    close_out();
  end
endmodule // etx_stats_test

`default_nettype wire
